// ---- core/fsef_flags.sv ----
// Flash status and error flags with a classic Wishbone register slave.
// Assumes the command sequencer, protection check and ECC detector run on
// core_clk and deliver one-cycle event pulses and levels.
//
// Overview of operation
// - Double-fault interrupt asserted while double flag set and its enable high.
// - Single-fault interrupt requested while single flag set and enable high.
// - Writing one to command-complete clears it and launches; stays low until done.
// - Command-complete reads zero during a command, one after it finishes.
// - Access-error set on sequence violation or illegal command.
// - While access-error set, writing command-complete neither clears nor launches.
// - Access-error clears only on write of one; zero has no effect.
// - Protection-violation set when program or erase targets protected region.
// - Protection-violation clears on write one; blocks launch and sequence start.
// - Busy bit reads one while a command executes, zero when idle.
// - Status bit 2 reserved, reads zero, ignores writes.
// - Completion-status bits set when a command or reset sequence finds an error.
// - Only complete, access-error, protection flags writable; others read-only.
// - Double flag set on double fault or read colliding with a command.
// - Single flag set on corrected fault unless suppressed, or on collision.
// - Fault flags clear only on write of one.
// - ECC fault sets one flag only; both together mean a collision.
// - Status reset contents may differ after reset-time double fault.
// - Suppression bit blocks single flag and its interrupt for read faults.
// - Command-complete interrupt requested while flag set and enable high.
// - Force-double makes every array read set the double flag.
// - Force-single makes every array read set the single flag, unless suppressed or that same read sets the double flag.
//
// Chosen here: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`include "fsef_regs.svh"

module fsef_flags
  import fsef_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Command sequencer
  input  wire logic              cmd_done,
  input  wire logic              cmd_violation,
  input  wire logic              cmd_illegal,
  input  wire logic              prot_violation,
  input  wire logic              cmd_error,
  input  wire logic [1:0]        cmd_error_code,
  input  wire logic              init_done,
  input  wire logic              init_dbl_fault,
  input  wire logic [1:0]        init_error_code,
  // Array read fault detection
  input  wire logic              array_read,
  input  wire logic              ecc_single,
  input  wire logic              ecc_double,
  input  wire logic              read_collision,
  // To the sequencer
  output logic                   cmd_launch,
  output logic                   seq_allowed,
  output logic                   busy_out,
  // Interrupt requests
  output logic                   cc_irq,
  output logic                   err_irq
);

  import fsef_pkg::*;

  if (ADDR_W < 4) begin : g_bad_addr_w
    $error("fsef_flags: ADDR_W must be at least 4");
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  fsef_bus_state_t bus_state_reg;
  fsef_byte_t      config_reg;
  fsef_byte_t      err_cfg_reg;
  logic            command_complete_flag_reg;
  logic            busy_reg;
  logic [1:0]      cstat_reg;
  logic            access_error_flag_flag;
  logic            protection_violation_flag_flag;
  logic            dbl_flag;
  logic            sgl_flag;

  function automatic logic hit(input logic [ADDR_W-1:0] adr,
                               input logic [3:0] ofs);
    hit = (adr[3:0] == ofs) && (adr[ADDR_W-1:2] >> 2 == '0);
  endfunction

  logic       req;
  logic       wr_lane0;
  fsef_byte_t wbyte;
  logic       wr_cfg;
  logic       wr_ecfg;
  logic       wr_stat;
  logic       wr_eflg;

  assign req      = wb_cyc_i && wb_stb_i && (bus_state_reg == FSEF_BUS_IDLE);
  assign wr_lane0 = req && wb_we_i && wb_sel_i[0];
  assign wbyte    = wb_dat_i[7:0];
  assign wr_cfg   = wr_lane0 && hit(wb_adr_i, `FSEF_OFS_CONFIG);
  assign wr_ecfg  = wr_lane0 && hit(wb_adr_i, `FSEF_OFS_ERR_CFG);
  assign wr_stat  = wr_lane0 && hit(wb_adr_i, `FSEF_OFS_STATUS);
  assign wr_eflg  = wr_lane0 && hit(wb_adr_i, `FSEF_OFS_ERR_FLAGS);

  // One-cycle ack, then a dead cycle so ack drops after each answer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_reg <= FSEF_BUS_IDLE;
    end else begin
      unique case (bus_state_reg)
        FSEF_BUS_IDLE: begin
          if (wb_cyc_i && wb_stb_i) begin
            bus_state_reg <= FSEF_BUS_ACK;
          end
        end
        FSEF_BUS_ACK:  bus_state_reg <= FSEF_BUS_WAIT;
        FSEF_BUS_WAIT: bus_state_reg <= FSEF_BUS_IDLE;
        default:       bus_state_reg <= FSEF_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_reg <= `FSEF_RST_CONFIG;
    end else if (wr_cfg) begin
      config_reg <= wbyte & `FSEF_CFG_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_cfg_reg <= `FSEF_RST_ERR_CFG;
    end else if (wr_ecfg) begin
      err_cfg_reg <= wbyte & `FSEF_ECFG_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command status

  logic init_busy_reg;
  logic launch_req;
  logic access_error_flag_clr;
  logic protection_violation_flag_clr;

  // Launch refused while either error flag is set
  assign launch_req = wr_stat && wbyte[`FSEF_ST_COMMAND_COMPLETE_FLAG] && command_complete_flag_reg
                      && !access_error_flag_flag && !protection_violation_flag_flag
                      && !cmd_done && !cmd_violation && !cmd_illegal
                      && !prot_violation;
  // Write one clears, zero leaves
  assign access_error_flag_clr = wr_stat && wbyte[`FSEF_ST_ACCESS_ERROR_FLAG];
  assign protection_violation_flag_clr = wr_stat && wbyte[`FSEF_ST_PROTECTION_VIOLATION_FLAG];

  // Reset sequence pending until init completes; gates only the status load, not busy
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_busy_reg <= 1'b1;
    end else if (init_done) begin
      init_busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      command_complete_flag_reg <= 1'b1;
    end else if (cmd_done || cmd_violation || cmd_illegal
                 || prot_violation) begin
      command_complete_flag_reg <= 1'b1;
    end else if (launch_req) begin
      command_complete_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
    end else if (cmd_done || cmd_violation || cmd_illegal
                 || prot_violation) begin
      busy_reg <= 1'b0;
    end else if (launch_req) begin
      busy_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cstat_reg <= 2'h0;
    end else if (init_busy_reg && init_done) begin
      cstat_reg <= init_dbl_fault ? (init_error_code | 2'h2)
                                  : init_error_code;
    end else if (launch_req) begin
      cstat_reg <= 2'h0;
    end else if (cmd_done && cmd_error) begin
      cstat_reg <= (cmd_error_code == 2'h0) ? 2'h1 : cmd_error_code;
    end
  end

  fsef_sticky u_access_error_flag (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .rst_val   (1'b0),
    .set_pulse (cmd_violation || cmd_illegal),
    .clr_pulse (access_error_flag_clr),
    .flag_reg  (access_error_flag_flag)
  );

  fsef_sticky u_protection_violation_flag (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .rst_val   (1'b0),
    .set_pulse (prot_violation),
    .clr_pulse (protection_violation_flag_clr),
    .flag_reg  (protection_violation_flag_flag)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_launch  <= 1'b0;
      seq_allowed <= 1'b0;
      busy_out    <= 1'b0;
    end else begin
      cmd_launch  <= launch_req;
      seq_allowed <= !protection_violation_flag_flag && !access_error_flag_flag && command_complete_flag_reg;
      busy_out    <= busy_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ECC error flags

  logic sgl_set;
  logic dbl_set;
  logic sgl_ecc;
  logic dbl_ecc;

  // double wins over single for one fault
  assign dbl_ecc = array_read
                   && (ecc_double || config_reg[`FSEF_CFG_FORCE_DBL]);
  assign sgl_ecc = array_read && !dbl_ecc
                   && !config_reg[`FSEF_CFG_SUPPRESS]
                   && (ecc_single || config_reg[`FSEF_CFG_FORCE_SGL]);
  assign dbl_set = dbl_ecc || read_collision;
  assign sgl_set = sgl_ecc || read_collision;

  fsef_sticky u_dbl (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .rst_val   (1'b0),
    .set_pulse (dbl_set),
    .clr_pulse (wr_eflg && wbyte[`FSEF_EF_DBL]),
    .flag_reg  (dbl_flag)
  );

  fsef_sticky u_sgl (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .rst_val   (1'b0),
    .set_pulse (sgl_set),
    .clr_pulse (wr_eflg && wbyte[`FSEF_EF_SGL]),
    .flag_reg  (sgl_flag)
  );

  ////////////////////////////////////////////////////////////////////////
  // Interrupt requests

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_irq <= 1'b0;
    end else begin
      err_irq <= (dbl_flag && err_cfg_reg[`FSEF_ECFG_DBL_IE])
              || (sgl_flag && err_cfg_reg[`FSEF_ECFG_SGL_IE]);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cc_irq <= 1'b0;
    end else begin
      cc_irq <= command_complete_flag_reg && config_reg[`FSEF_CFG_COMMAND_COMPLETE_IRQ_ENABLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data

  fsef_byte_t status_byte;
  fsef_byte_t rd_byte;

  always_comb begin
    status_byte                    = 8'h00;
    status_byte[`FSEF_ST_COMMAND_COMPLETE_FLAG]     = command_complete_flag_reg;
    status_byte[`FSEF_ST_ACCESS_ERROR_FLAG]   = access_error_flag_flag;
    status_byte[`FSEF_ST_PROTECTION_VIOLATION_FLAG]   = protection_violation_flag_flag;
    status_byte[`FSEF_ST_BUSY]     = busy_reg;
    status_byte[`FSEF_ST_CSTAT_HI] = cstat_reg[1];
    status_byte[`FSEF_ST_CSTAT_LO] = cstat_reg[0];
  end

  always_comb begin
    rd_byte = 8'h00;
    if (hit(wb_adr_i, `FSEF_OFS_CONFIG)) begin
      rd_byte = config_reg;
    end else if (hit(wb_adr_i, `FSEF_OFS_ERR_CFG)) begin
      rd_byte = err_cfg_reg;
    end else if (hit(wb_adr_i, `FSEF_OFS_STATUS)) begin
      rd_byte = status_byte;
    end else if (hit(wb_adr_i, `FSEF_OFS_ERR_FLAGS)) begin
      rd_byte = {6'h00, dbl_flag, sgl_flag};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

endmodule // fsef_flags

// ---- core/fsef_pkg.sv ----
// Types shared by the flash status and error-flag block.
// Assumes fsef_regs.svh sits on the include path.
`include "fsef_regs.svh"

package fsef_pkg;

  typedef enum logic [1:0] {
    FSEF_REG_CONFIG    = 2'b00,
    FSEF_REG_ERR_CFG   = 2'b01,
    FSEF_REG_STATUS    = 2'b10,
    FSEF_REG_ERR_FLAGS = 2'b11
  } fsef_reg_sel_t;

  typedef enum logic [1:0] {
    FSEF_BUS_IDLE = 2'b00,
    FSEF_BUS_ACK  = 2'b01,
    FSEF_BUS_WAIT = 2'b10
  } fsef_bus_state_t;

  typedef logic [7:0] fsef_byte_t;

endpackage : fsef_pkg

// ---- core/fsef_regs.svh ----
// Register offsets, field positions and reset values of the flash status
// and error-flag block. Included by the package and by fsef_flags.
`ifndef FSEF_REGS_SVH
`define FSEF_REGS_SVH

// Word offsets on the Wishbone bus (byte addresses)
`define FSEF_OFS_CONFIG      4'h0
`define FSEF_OFS_ERR_CFG     4'h4
`define FSEF_OFS_STATUS      4'h8
`define FSEF_OFS_ERR_FLAGS   4'hC

// flash_configuration fields
`define FSEF_CFG_COMMAND_COMPLETE_IRQ_ENABLE        7
`define FSEF_CFG_SUPPRESS    4
`define FSEF_CFG_FORCE_DBL   1
`define FSEF_CFG_FORCE_SGL   0
`define FSEF_CFG_MASK        8'h93

// error_irq_enable fields
`define FSEF_ECFG_DBL_IE     1
`define FSEF_ECFG_SGL_IE     0
`define FSEF_ECFG_MASK       8'h03

// command_status fields
`define FSEF_ST_COMMAND_COMPLETE_FLAG         7
`define FSEF_ST_ACCESS_ERROR_FLAG       5
`define FSEF_ST_PROTECTION_VIOLATION_FLAG       4
`define FSEF_ST_BUSY         3
`define FSEF_ST_RSVD         2
`define FSEF_ST_CSTAT_HI     1
`define FSEF_ST_CSTAT_LO     0

// ecc_error_flags fields
`define FSEF_EF_DBL          1
`define FSEF_EF_SGL          0

// Reset values
`define FSEF_RST_CONFIG      8'h00
`define FSEF_RST_ERR_CFG     8'h00
`define FSEF_RST_STATUS      8'h80
`define FSEF_RST_ERR_FLAGS   8'h00

`endif

// ---- core/fsef_sticky.sv ----
// Sticky flag with write-one-to-clear; a hardware set wins over a clear.
// Assumes set and clear are single-cycle strobes on the same clock.
`timescale 1ns/10ps

module fsef_sticky (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic rst_val,
  input  wire logic set_pulse,
  input  wire logic clr_pulse,
  output logic      flag_reg
);

  // Set has priority over clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (set_pulse) begin
      flag_reg <= 1'b1;
    end else if (clr_pulse) begin
      flag_reg <= 1'b0;
    end
  end

endmodule // fsef_sticky

// ---- verif/fsef_flags_asserts.sv ----
// Port-level checker for the flash status and error-flag block.
// Assumes single-cycle classic Wishbone requests and one clock.
`timescale 1ns/10ps

module fsef_flags_chk #(
  parameter int ADDR_W = 4
) (
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              array_read,
  input wire logic              read_collision,
  input wire logic              cmd_launch,
  input wire logic              seq_allowed,
  input wire logic              busy_out,
  input wire logic              cc_irq,
  input wire logic              err_irq
);
  logic ev;
  logic st_wr;
  assign ev = read_collision | array_read | (wb_cyc_i & wb_stb_i & wb_we_i);
  assign st_wr = wb_we_i && wb_adr_i == ADDR_W'(8);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_upper_bytes_zero: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bytes not zero");
  a_launch_cause: assert property (
    cmd_launch |-> $past(st_wr) || $past(st_wr, 2))
    else $error("launch without status write");
  a_launch_pulse: assert property (cmd_launch |=> !cmd_launch)
    else $error("launch longer than one cycle");
  a_launch_closes: assert property (cmd_launch |=> !seq_allowed)
    else $error("sequence still allowed after launch");
  a_busy_no_ccirq: assert property (busy_out |-> !cc_irq)
    else $error("complete interrupt while busy");
  a_ready_not_busy: assert property (seq_allowed |-> !busy_out)
    else $error("sequence allowed while busy");
  a_err_irq_cause: assert property (
    $rose(err_irq) |-> $past(ev) || $past(ev, 2) || $past(ev, 3))
    else $error("error interrupt without cause");
  a_quiet_after_reset: assert property (
    $rose(rst_n) |-> !err_irq && !cc_irq && !cmd_launch)
    else $error("output active right after reset");
  c_launch: cover property (cmd_launch);
  c_err_irq: cover property ($rose(err_irq));
  c_cc_irq: cover property ($rose(cc_irq));
endmodule // fsef_flags_chk

bind fsef_flags fsef_flags_chk #(.ADDR_W(ADDR_W)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .array_read(array_read),
  .read_collision(read_collision), .cmd_launch(cmd_launch),
  .seq_allowed(seq_allowed), .busy_out(busy_out), .cc_irq(cc_irq),
  .err_irq(err_irq));

// ---- verif/test_flash_status_error_flags.sv ----
// Self-checking bench for the flash status and error-flag block.
// Assumes the checker is bound in from its own file.
`timescale 1ns/10ps

module test_flash_status_error_flags;
  import fsef_pkg::*;
  logic core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cmd_error;
  logic init_dbl_fault, cmd_launch, seq_allowed, busy_out, cc_irq, err_irq;
  logic cmd_done, cmd_violation, cmd_illegal, prot_violation, init_done;
  logic array_read, ecc_single, ecc_double, read_collision;
  logic [4:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i;
  logic [1:0]  cmd_error_code, init_error_code;
  logic [8:0]  evs;
  logic [7:0]  d, q;
  int          errors, checked, launches, n0;
  localparam logic [8:0] DONE = 9'h100, VIOL = 9'h080, ILL = 9'h040;
  localparam logic [8:0] PROT = 9'h020, INIT = 9'h010, RD = 9'h008;
  localparam logic [8:0] SGL = 9'h004, DBL = 9'h002, COL = 9'h001;
  assign {cmd_done, cmd_violation, cmd_illegal, prot_violation, init_done,
          array_read, ecc_single, ecc_double, read_collision} = evs;

  fsef_flags #(.ADDR_W(5)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cmd_done(cmd_done), .cmd_violation(cmd_violation),
    .cmd_illegal(cmd_illegal), .prot_violation(prot_violation),
    .cmd_error(cmd_error), .cmd_error_code(cmd_error_code),
    .init_done(init_done), .init_dbl_fault(init_dbl_fault),
    .init_error_code(init_error_code), .array_read(array_read),
    .ecc_single(ecc_single), .ecc_double(ecc_double),
    .read_collision(read_collision), .cmd_launch(cmd_launch),
    .seq_allowed(seq_allowed), .busy_out(busy_out), .cc_irq(cc_irq),
    .err_irq(err_irq));

  always #25 core_clk = ~core_clk;
  always @(negedge core_clk) if (cmd_launch === 1'b1) launches++;

  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("Counts: checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; e rides with the request into the taking edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v,
                     input logic [8:0] e, output logic [7:0] r);
    int n;
    @(posedge core_clk);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, v};
    evs <= e;
    @(posedge core_clk);
    evs <= 9'h000;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      errors++;
      print_verdict();
    end
    @(posedge core_clk);
    r = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    logic [7:0] r;
    bus(1'b1, a, v, 9'h000, r);
  endtask

  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, 9'h000, r);
    chk(r, e);
  endtask

  task automatic pulse(input logic [8:0] e);
    @(posedge core_clk);
    evs <= e;
    @(posedge core_clk);
    evs <= 9'h000;
  endtask

  task automatic launch(input logic [7:0] expect_n);
    n0 = launches;
    wr(5'h08, 8'h80);
    chk(8'(launches - n0), expect_n);
  endtask

  function automatic logic [1:0] exp_cs(input logic [1:0] c);
    return (c == 2'h0) ? 2'h1 : c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, cmd_error} = '0;
    {init_dbl_fault, wb_adr_i, wb_dat_i, evs} = '0;
    {cmd_error_code, init_error_code, errors, checked, launches} = '0;
    wb_sel_i = 4'hF;
    void'($urandom(27));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rc(5'h00, 8'h00);
    rc(5'h04, 8'h00);
    rc(5'h08, 8'h80);
    rc(5'h0C, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      wr(5'h00, d);
      rc(5'h00, d & 8'h93);
      wr(5'h04, d);
      rc(5'h04, d & 8'h03);
    end
    wr(5'h10, 8'hFF);
    rc(5'h10, 8'h00);
    rc(5'h00, d & 8'h93);
    {q} = '0;
    wr(5'h00, 8'h80);
    wr(5'h04, 8'h00);
    wr(5'h08, 8'h7F);
    rc(5'h08, 8'h80);
    chk({7'h0, cc_irq}, 8'h01);
    $display("test config done");
    for (int c = 0; c < 4; c++) begin
      launch(8'h01);
      rc(5'h08, 8'h08);
      chk({7'h0, cc_irq}, 8'h00);
      cmd_error <= 1'b1;
      cmd_error_code <= 2'(c);
      pulse(DONE);
      rc(5'h08, {6'h20, exp_cs(2'(c))});
      chk({7'h0, cc_irq}, 8'h01);
    end
    cmd_error <= 1'b0;
    launch(8'h01);
    pulse(DONE);
    rc(5'h08, 8'h80);
    $display("test launch done");
    pulse(ILL);
    rc(5'h08, 8'hA0);
    launch(8'h00);
    rc(5'h08, 8'hA0);
    wr(5'h08, 8'h00);
    rc(5'h08, 8'hA0);
    wr(5'h08, 8'h20);
    rc(5'h08, 8'h80);
    launch(8'h01);
    pulse(VIOL);
    rc(5'h08, 8'hA0);
    wr(5'h08, 8'h20);
    pulse(PROT);
    rc(5'h08, 8'h90);
    chk({7'h0, seq_allowed}, 8'h00);
    launch(8'h00);
    wr(5'h08, 8'h10);
    rc(5'h08, 8'h80);
    chk({7'h0, seq_allowed}, 8'h01);
    init_dbl_fault <= 1'b1;
    pulse(INIT);
    rc(5'h08, 8'h82);
    $display("test status done");
    wr(5'h00, 8'h00);
    wr(5'h04, 8'h03);
    pulse(RD | SGL);
    rc(5'h0C, 8'h01);
    chk({7'h0, err_irq}, 8'h01);
    wr(5'h0C, 8'h00);
    rc(5'h0C, 8'h01);
    wr(5'h04, 8'h02);
    @(negedge core_clk);
    chk({7'h0, err_irq}, 8'h00);
    wr(5'h0C, 8'h01);
    pulse(RD | DBL | SGL);
    rc(5'h0C, 8'h02);
    chk({7'h0, err_irq}, 8'h01);
    wr(5'h0C, 8'h02);
    bus(1'b1, 5'h0C, 8'h03, COL, q);
    rc(5'h0C, 8'h03);
    wr(5'h0C, 8'h03);
    rc(5'h0C, 8'h00);
    chk({7'h0, err_irq}, 8'h00);
    wr(5'h04, 8'h03);
    wr(5'h00, 8'h10);
    pulse(RD | SGL);
    rc(5'h0C, 8'h00);
    chk({7'h0, err_irq}, 8'h00);
    wr(5'h00, 8'h02);
    pulse(RD);
    rc(5'h0C, 8'h02);
    wr(5'h0C, 8'h02);
    wr(5'h00, 8'h01);
    pulse(RD);
    rc(5'h0C, 8'h01);
    chk({7'h0, err_irq}, 8'h01);
    $display("test fault flags done");
    print_verdict();
  end
endmodule // test_flash_status_error_flags
